// *** hw/pfm_pin_mux.v ***
// Pin function multiplexer: boot status, irq lines, I2C pins, alternate functions, flash port
//
// How it works
// - Boot status pin low until boot done
// - Reset input high restores every setting
// - Host port irq pulls low, open drain
// - Third port controller only; low detect requests
// - I2C pins only ever driven low
// - Alt mode routes hotplug both ways
// - Pins fourteen, fifteen selectable as pulse outputs
// - Pins sixteen, seventeen enable external paths
// - Flash controller drives clock, select, data
// - Pins reset to undriven inputs
`timescale 1ns/1ps
`include "pfm_defs.vh"
`default_nettype none
module pfm_pin_mux (
   input  wire       clock,
   input  wire       srst,
   input  wire       ce,
   input  wire       hw_reset_in,
   input  wire       boot_done,
   input  wire       host_a_irq_pending,
   input  wire       host_b_irq_pending,
   output reg        host_port_a_irq_n_oe,
   output reg        host_port_b_irq_n_oe,
   output reg        host_port_a_irq_n_o,
   output reg        host_port_b_irq_n_o,
   output reg        boot_status_pin_o,
   output reg        boot_status_pin_oe,
   input  wire [5:0] i2c_pin_i,
   input  wire [5:0] i2c_pull_low,
   output reg  [5:0] i2c_pin_o,
   output reg  [5:0] i2c_pin_oe,
   output reg  [5:0] i2c_pin_level,
   input  wire       ctrl_port_irq_detect_n,
   output reg        ctrl_port_irq_req,
   input  wire       dp_alt_enable,
   input  wire       hpd_tx_level,
   input  wire       hotplug_detect_pin_i,
   output reg        hotplug_detect_pin_o,
   output reg        hotplug_detect_pin_oe,
   output reg        hpd_rx_level,
   input  wire       pwm_a_select,
   input  wire       pwm_b_select,
   input  wire [7:0] pwm_a_duty,
   input  wire [7:0] pwm_b_duty,
   output reg        pulse_out_a,
   output reg        pulse_out_a_oe,
   output reg        pulse_out_b,
   output reg        pulse_out_b_oe,
   input  wire       path_a_select,
   input  wire       path_b_select,
   input  wire       path_a_on,
   input  wire       path_b_on,
   output reg        ext_path_a_enable,
   output reg        ext_path_a_enable_oe,
   output reg        ext_path_b_enable,
   output reg        ext_path_b_enable_oe,
   input  wire       flash_start,
   input  wire [7:0] flash_tx_byte,
   output reg  [7:0] flash_rx_byte,
   output reg        flash_busy,
   output reg        flash_done,
   input  wire       flash_data_in,
   output reg        flash_data_out,
   output reg        flash_clk,
   output reg        flash_cs_n,
   output reg        flash_pins_oe
);
   // Either reset source clears all state but the reset pin synchroniser, which only srst clears
   wire rst_any;
   wire [8:0] pin_sync;
   reg        hw_rst_meta_reg;
   reg        hw_rst_reg;
   reg  [`PFM_PWM_W-1:0] pwm_cnt_reg;
   reg  [3:0] div_reg;
   reg  [3:0] bit_cnt_reg;
   reg  [7:0] shift_reg;
   reg        run_reg;
   integer    k;

   // Reset pin comes from outside, so it is synchronised too
   always @(posedge clock)
   begin
      if (srst)
      begin
         hw_rst_meta_reg <= 1'b0;
         hw_rst_reg      <= 1'b0;
      end
      else if (ce)
      begin
         hw_rst_meta_reg <= hw_reset_in;
         hw_rst_reg      <= hw_rst_meta_reg;
      end
   end
   assign rst_any = srst | hw_rst_reg;

   // Pin inputs: 6 I2C lines, irq detect, hotplug, flash data
   // Detect line enters inverted so the synchroniser's reset zero means no request
   pfm_sync #(.W(9)) u_sync (
      .clock (clock),
      .srst  (rst_any),
      .ce    (ce),
      .d     ({flash_data_in, hotplug_detect_pin_i, ~ctrl_port_irq_detect_n, i2c_pin_i}),
      .q     (pin_sync)
   );

   // Free-running pulse width counter shared by both outputs
   always @(posedge clock)
   begin
      if (rst_any)
         pwm_cnt_reg <= `PFM_PWM_RST;
      else if (ce)
         pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
   end

   // Pin drivers; all enables low after reset so pins float as inputs
   always @(posedge clock)
   begin
      if (rst_any)
      begin
         boot_status_pin_o     <= 1'b0;
         boot_status_pin_oe    <= `PFM_OE_RST;
         host_port_a_irq_n_o   <= 1'b0;
         host_port_b_irq_n_o   <= 1'b0;
         host_port_a_irq_n_oe  <= `PFM_OE_RST;
         host_port_b_irq_n_oe  <= `PFM_OE_RST;
         i2c_pin_o             <= 6'h00;
         i2c_pin_oe            <= 6'h00;
         i2c_pin_level         <= 6'h00;
         ctrl_port_irq_req     <= 1'b0;
         hotplug_detect_pin_o  <= 1'b0;
         hotplug_detect_pin_oe <= `PFM_OE_RST;
         hpd_rx_level          <= 1'b0;
         pulse_out_a           <= 1'b0;
         pulse_out_a_oe        <= `PFM_OE_RST;
         pulse_out_b           <= 1'b0;
         pulse_out_b_oe        <= `PFM_OE_RST;
         ext_path_a_enable     <= 1'b0;
         ext_path_a_enable_oe  <= `PFM_OE_RST;
         ext_path_b_enable     <= 1'b0;
         ext_path_b_enable_oe  <= `PFM_OE_RST;
      end
      else if (ce)
      begin
         // Boot pin held low until boot finishes, then released
         boot_status_pin_o    <= 1'b0;
         boot_status_pin_oe   <= ~boot_done;
         // Irq lines: drive low when pending, float otherwise
         host_port_a_irq_n_o  <= 1'b0;
         host_port_b_irq_n_o  <= 1'b0;
         host_port_a_irq_n_oe <= host_a_irq_pending;
         host_port_b_irq_n_oe <= host_b_irq_pending;
         // Third port is controller only; low detect line means request
         ctrl_port_irq_req    <= pin_sync[6];
         // Hotplug: transmit when alt mode on, receive sampled only when alt mode on
         hotplug_detect_pin_o  <= hpd_tx_level;
         hotplug_detect_pin_oe <= dp_alt_enable;
         hpd_rx_level          <= dp_alt_enable & pin_sync[7];
         // Pulse outputs only when selected
         pulse_out_a    <= pwm_a_select & (pwm_cnt_reg < pwm_a_duty);
         pulse_out_a_oe <= pwm_a_select;
         pulse_out_b    <= pwm_b_select & (pwm_cnt_reg < pwm_b_duty);
         pulse_out_b_oe <= pwm_b_select;
         // External path enables driven both ways once selected
         ext_path_a_enable    <= path_a_select & path_a_on;
         ext_path_a_enable_oe <= path_a_select;
         ext_path_b_enable    <= path_b_select & path_b_on;
         ext_path_b_enable_oe <= path_b_select;
         // Open drain: data always zero, enable pulls the line low
         for (k = 0; k < 6; k = k + 1)
         begin
            i2c_pin_o[k]     <= 1'b0;
            i2c_pin_oe[k]    <= i2c_pull_low[k];
            i2c_pin_level[k] <= pin_sync[k];
         end
      end
   end

   // Flash controller: mode 0, one byte per start, MSB first
   always @(posedge clock)
   begin
      if (rst_any)
      begin
         run_reg        <= 1'b0;
         div_reg        <= 4'h0;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         flash_rx_byte  <= 8'h00;
         flash_busy     <= 1'b0;
         flash_done     <= 1'b0;
         flash_data_out <= 1'b0;
         flash_clk      <= 1'b0;
         flash_cs_n     <= 1'b1;
         flash_pins_oe  <= `PFM_OE_RST;
      end
      else if (ce)
      begin
         flash_done <= 1'b0;
         if (!run_reg)
         begin
            flash_clk <= 1'b0;
            if (flash_start)
            begin
               run_reg        <= 1'b1;
               flash_busy     <= 1'b1;
               flash_pins_oe  <= 1'b1;
               flash_cs_n     <= 1'b0;
               shift_reg      <= flash_tx_byte;
               flash_data_out <= flash_tx_byte[7];
               bit_cnt_reg    <= 4'h0;
               div_reg        <= 4'h0;
            end
         end
         else if (div_reg == `PFM_SPI_HALF - 4'h1)
         begin
            div_reg <= 4'h0;
            if (!flash_clk)
            begin
               // Rising edge: peripheral bit is still passing the synchroniser
               flash_clk <= 1'b1;
            end
            else
            begin
               // Falling edge: synced input shows the bit set up at the last fall;
               // this relies on the half period matching the two-flop latency
               flash_clk <= 1'b0;
               if (bit_cnt_reg == `PFM_SPI_BITS - 4'h1)
               begin
                  run_reg       <= 1'b0;
                  flash_busy    <= 1'b0;
                  flash_done    <= 1'b1;
                  flash_cs_n    <= 1'b1;
                  flash_rx_byte <= {shift_reg[6:0], pin_sync[8]};
               end
               else
               begin
                  bit_cnt_reg    <= bit_cnt_reg + 4'h1;
                  shift_reg      <= {shift_reg[6:0], pin_sync[8]};
                  flash_data_out <= shift_reg[6];
               end
            end
         end
         else
            div_reg <= div_reg + 4'h1;
      end
   end
endmodule // pfm_pin_mux
`default_nettype wire

// *** hw/pfm_sync.v ***
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pfm_sync #(
   parameter W = 8
) (
   input  wire         clock,
   input  wire         srst,
   input  wire         ce,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always @(posedge clock)
   begin
      if (srst)
      begin
         meta_reg <= {W{1'b0}};
         q        <= {W{1'b0}};
      end
      else if (ce)
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // pfm_sync
`default_nettype wire

// *** shared/pfm_defs.vh ***
// Constants of the pin function multiplexer
`ifndef PFM_DEFS_VH
`define PFM_DEFS_VH
// Pulse generator counter width and reset values
`define PFM_PWM_W        8
`define PFM_PWM_RST      8'h00
// Function select codes for the alternate pins
`define PFM_SEL_GPIO     1'b0
`define PFM_SEL_ALT      1'b1
// Flash clock divider: half period in core cycles
`define PFM_SPI_HALF     4'h2
`define PFM_SPI_BITS     4'h8
// Reset value of any pin output enable
`define PFM_OE_RST       1'b0
`endif

// *** verif/pfm_chk.sv ***
// Checker of pin multiplexer port relations
`timescale 1ns/1ps
`default_nettype none
module pfm_chk (
   input wire logic       clock,
   input wire logic       srst,
   input wire logic       hw_reset_in,
   input wire logic       boot_done,
   input wire logic       boot_status_pin_oe,
   input wire logic       host_a_irq_pending,
   input wire logic       host_port_a_irq_n_oe,
   input wire logic [5:0] i2c_pull_low,
   input wire logic [5:0] i2c_pin_o,
   input wire logic [5:0] i2c_pin_oe,
   input wire logic       ctrl_port_irq_detect_n,
   input wire logic       ctrl_port_irq_req,
   input wire logic       path_a_select,
   input wire logic       path_a_on,
   input wire logic       ext_path_a_enable,
   input wire logic       flash_start,
   input wire logic       flash_busy,
   input wire logic       flash_done,
   input wire logic       flash_cs_n
);
   // Pin reset is synchronised inside, so stay quiet a few edges after it
   logic [3:0] hr_hist_reg = 4'h0;
   always @(posedge clock) hr_hist_reg <= {hr_hist_reg[2:0], hw_reset_in};
   default clocking @(posedge clock); endclocking
   default disable iff (srst || hw_reset_in || |hr_hist_reg);
   // One byte frame: selected while busy, done 32 cycles on
   sequence s_go; flash_start && !flash_busy; endsequence
   sequence s_frame; flash_busy && !flash_cs_n ##32 flash_done && flash_cs_n; endsequence
   chk_boot_hold:
   assert property (1'b1 |=> boot_status_pin_oe == !$past(boot_done)) else $error("boot");
   chk_irq_pull:
   assert property (host_a_irq_pending |=> host_port_a_irq_n_oe) else $error("irq");
   chk_irq_free:
   assert property (!host_a_irq_pending |=> !host_port_a_irq_n_oe) else $error("irq");
   chk_i2c_drain:
   assert property (1'b1 |=> i2c_pin_o == 6'h00 && i2c_pin_oe == $past(i2c_pull_low))
      else $error("i2c");
   chk_detect_req:
   assert property ((!ctrl_port_irq_detect_n) [*5] |-> ctrl_port_irq_req) else $error("det");
   chk_path_en:
   assert property (path_a_select && path_a_on |=> ext_path_a_enable) else $error("path");
   chk_flash_frame:
   assert property (s_go |=> s_frame) else $error("flash");
   chk_reset_idle:
   assert property (disable iff (1'b0) srst |=> flash_cs_n && i2c_pin_oe == 6'h00)
      else $error("reset");
endmodule // pfm_chk
`default_nettype wire

// *** verif/pfm_flash.sv ***
// Behavioural flash device at the far end of the serial port
`timescale 1ns/1ps
`default_nettype none
module pfm_flash (
   input  wire logic       flash_clk,
   input  wire logic       flash_cs_n,
   input  wire logic       flash_data_out,
   input  wire logic [7:0] reply,
   output var  logic       flash_data_in,
   output var  logic [7:0] got
);
   logic [7:0] sh_reg = 8'h00;
   logic       sel_prev_n_reg = 1'b1;
   // Reply MSB first, next bit after each falling clock
   // One process owns the shifter: load on select, shift on each fall
   always @(flash_cs_n or negedge flash_clk)
   begin
      if (!flash_cs_n && sel_prev_n_reg)
         sh_reg = reply;
      else if (!flash_cs_n)
         sh_reg = {sh_reg[6:0], ~sh_reg[7]};
      sel_prev_n_reg = flash_cs_n;
   end
   // Deselected, the line shows the inverse so a stale bit never passes
   assign flash_data_in = flash_cs_n ^ sh_reg[7];
   // Take the controller's bit on each rising clock
   always @(posedge flash_clk) got <= {got[6:0], flash_data_out};
endmodule // pfm_flash
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench of the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock, srst, ce, hw_reset_in, boot_done, host_a_irq_pending, host_b_irq_pending;
   logic host_port_a_irq_n_oe, host_port_b_irq_n_oe, host_port_a_irq_n_o, host_port_b_irq_n_o;
   logic boot_status_pin_o, boot_status_pin_oe, ctrl_port_irq_detect_n, ctrl_port_irq_req;
   logic dp_alt_enable, hpd_tx_level, hotplug_detect_pin_o, hotplug_detect_pin_oe, hpd_ext;
   logic hpd_rx_level, pwm_a_select, pwm_b_select, pulse_out_a, pulse_out_a_oe, pulse_out_b;
   logic pulse_out_b_oe, path_a_select, path_b_select, path_a_on, path_b_on, flash_start;
   logic ext_path_a_enable, ext_path_a_enable_oe, ext_path_b_enable, ext_path_b_enable_oe;
   logic flash_busy, flash_done, flash_data_in, flash_data_out, flash_clk, flash_cs_n;
   logic flash_pins_oe;
   logic [5:0] i2c_ext, i2c_pull_low, i2c_pin_o, i2c_pin_oe, i2c_pin_level;
   logic [7:0] pwm_a_duty, pwm_b_duty, flash_tx_byte, flash_rx_byte, reply, got;
   int bad_count = 0, checked = 0, n, m;
   // Wires: pulled up unless some party pulls low or drives
   wire [5:0] i2c_pin_i = ~i2c_pin_oe & i2c_ext;
   wire hotplug_detect_pin_i = hotplug_detect_pin_oe ? hotplug_detect_pin_o : hpd_ext;
   pfm_pin_mux pfm_pin_mux_inst (.*);
   pfm_flash pfm_flash_inst (.*);
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      $display("checks %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_boot;
      cmp({flash_cs_n, flash_busy, i2c_pin_oe}, 8'h80);
      cmp({boot_status_pin_oe, boot_status_pin_o, pulse_out_a_oe, 5'h00}, 8'h80);
      boot_done = 1'b1;
      cyc(2);
      cmp({7'h00, boot_status_pin_oe}, 8'h00);
      $display("boot ok");
   endtask
   task automatic t_irq;
      for (int i = 0; i < 3; i++)
      begin
         {host_a_irq_pending, host_b_irq_pending} = 2'b10 >> i;
         cyc(2);
         cmp({host_port_a_irq_n_oe, host_port_b_irq_n_oe, host_port_a_irq_n_o,
              host_port_b_irq_n_o, 4'h0}, {2'b10 >> i, 6'h00});
      end
      $display("irq ok");
   endtask
   task automatic t_i2c;
      {i2c_pull_low, i2c_ext} = 12'habf;
      cyc(5);
      cmp({i2c_pin_oe, i2c_pin_o[1:0]}, 8'ha8);
      cmp({i2c_pin_level, 2'b00}, 8'h54);
      $display("i2c ok");
   endtask
   task automatic t_detect;
      ctrl_port_irq_detect_n = 1'b0; // target raises its request
      cyc(5);
      cmp({7'h00, ctrl_port_irq_req}, 8'h01);
      ctrl_port_irq_detect_n = 1'b1;
      cyc(5);
      cmp({7'h00, ctrl_port_irq_req}, 8'h00);
      $display("detect ok");
   endtask
   task automatic t_hpd;
      {hpd_ext, hpd_tx_level} = 2'b11;
      cyc(5);
      cmp({hotplug_detect_pin_oe, hpd_rx_level, 6'h00}, 8'h00);
      dp_alt_enable = 1'b1;
      cyc(5);
      cmp({hotplug_detect_pin_oe, hotplug_detect_pin_o, 5'h00, hpd_rx_level}, 8'hc1);
      $display("hpd ok");
   endtask
   task automatic t_pwm;
      {pwm_a_duty, pwm_b_duty, pwm_a_select} = 17'h0_8181;
      cyc(2);
      cmp({pulse_out_a_oe, pulse_out_b_oe, 6'h00}, 8'h80);
      pwm_b_select = 1'b1;
      {n, m} = 0;
      repeat (256)
      begin
         cyc(1);
         n += (pulse_out_a === 1'b1);
         m += (pulse_out_b === 1'b1);
      end
      cmp(n[7:0], 8'h40);
      cmp(m[7:0], 8'hc0);
      $display("pwm ok");
   endtask
   task automatic t_path;
      path_a_on = 1'b1;
      cyc(2);
      cmp({ext_path_a_enable, ext_path_a_enable_oe, 6'h00}, 8'h00);
      {path_a_select, path_b_select} = 2'b11;
      cyc(2);
      cmp({ext_path_a_enable, ext_path_a_enable_oe, ext_path_b_enable,
           ext_path_b_enable_oe, 4'h0}, 8'hd0);
      // Clock enable low must freeze the outputs
      ce = 1'b0;
      path_b_on = 1'b1;
      cyc(3);
      cmp({ext_path_b_enable, 7'h00}, 8'h00);
      ce = 1'b1;
      cyc(2);
      cmp({ext_path_b_enable, 7'h00}, 8'h80);
      $display("path ok");
   endtask
   task automatic t_flash;
      for (int i = 0; i < 2; i++)
      begin
         {reply, flash_tx_byte} = i ? 16'hc35a : 16'h3ca5;
         flash_start = 1'b1;
         cyc(1);
         flash_start = 1'b0;
         for (n = 0; flash_done !== 1'b1 && n < 60; n++)
            cyc(1);
         if (n == 60)
         begin
            bad_count++;
            test_done;
         end
         cmp(flash_rx_byte, reply);
         cmp(got, flash_tx_byte);
         cmp({flash_pins_oe, flash_busy, flash_cs_n, 5'h00}, 8'ha0);
      end
      $display("flash ok");
   endtask
   task automatic t_reset;
      hw_reset_in = 1'b1;
      cyc(4);
      cmp({ext_path_a_enable_oe, flash_cs_n, i2c_pin_oe}, 8'h40);
      hw_reset_in = 1'b0;
      cyc(6);
      srst = 1'b1;
      cyc(2);
      cmp({ext_path_a_enable_oe, flash_cs_n, i2c_pin_oe}, 8'h40);
      srst = 1'b0;
      cyc(2);
      $display("reset ok");
   endtask
   // Free-running core clock
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Main sequence, inputs driven on falling edges
   initial
   begin
      {srst, ce, ctrl_port_irq_detect_n, hw_reset_in, boot_done} = 5'h1c;
      {host_a_irq_pending, host_b_irq_pending, dp_alt_enable, hpd_tx_level, hpd_ext} = 5'h00;
      {pwm_a_select, pwm_b_select, path_a_select, path_b_select, path_a_on} = 5'h00;
      {path_b_on, flash_start, i2c_ext, i2c_pull_low} = 14'h0000;
      {pwm_a_duty, pwm_b_duty, flash_tx_byte, reply} = 32'h0000_0000;
      cyc(2);
      srst = 1'b0;
      cyc(1);
      t_boot;
      t_irq;
      t_i2c;
      t_detect;
      t_hpd;
      t_pwm;
      t_path;
      t_flash;
      t_reset;
      test_done;
   end
endmodule // tb_top
bind pfm_pin_mux pfm_chk pfm_chk_inst (.*);
`default_nettype wire
